// file: src/fcs_defines.svh
`ifndef FCS_DEFINES_SVH
`define FCS_DEFINES_SVH

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define FCS_CLK_NS        40
`define FCS_WP_NS         50
`define FCS_WP_CYC        ((`FCS_WP_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_RD_NS         120
`define FCS_SYNC_CYC      2
`define FCS_RD_CYC        (((`FCS_RD_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS) + `FCS_SYNC_CYC)
`define FCS_ADD_NS        40000
`define FCS_ADD_CYC       (`FCS_ADD_NS / `FCS_CLK_NS)

// ------------------------------------------------------------
// command addresses (low bits only) and data
// ------------------------------------------------------------
`define FCS_ADDR_UNLOCK1  11'h555
`define FCS_ADDR_UNLOCK2  11'h2aa
`define FCS_DATA_UNLOCK1  8'haa
`define FCS_DATA_UNLOCK2  8'h55
`define FCS_CMD_RESET     8'hf0
`define FCS_CMD_IDENT     8'h90
`define FCS_CMD_PROG      8'ha0
`define FCS_CMD_BYPASS    8'h20
`define FCS_CMD_BYP_EXIT2 8'h00
`define FCS_CMD_ERASE     8'h80
`define FCS_CMD_CHIP      8'h10
`define FCS_CMD_SECT      8'h30
`define FCS_CMD_SUSPEND   8'hb0
`define FCS_CMD_RESUME    8'h30

// ------------------------------------------------------------
// status bits in a polled byte
// ------------------------------------------------------------
`define FCS_BIT_TOGGLE    6
`define FCS_BIT_TFAIL     5

`endif

// file: src/fcs_pkg.sv
`default_nettype none
package fcs_pkg;

   // ---------------------------------------------------------
   // operations a user may request
   // ---------------------------------------------------------
   typedef enum logic [3:0] {
      OP_READ      = 4'h0,
      OP_RESET     = 4'h1,
      OP_IDENT     = 4'h2,
      OP_PROG      = 4'h3,
      OP_BYP_ENTER = 4'h4,
      OP_BYP_PROG  = 4'h5,
      OP_BYP_EXIT  = 4'h6,
      OP_CHIP      = 4'h7,
      OP_SECT      = 4'h8,
      OP_SECT_ADD  = 4'h9,
      OP_SUSPEND   = 4'ha,
      OP_RESUME    = 4'hb
   } fcs_op_t;

   // ---------------------------------------------------------
   // sequencer states, one-hot
   // ---------------------------------------------------------
   typedef enum logic [6:0] {
      S_IDLE   = 7'h01,
      S_WADDR  = 7'h02,
      S_WPULSE = 7'h04,
      S_WGAP   = 7'h08,
      S_READ   = 7'h10,
      S_RGAP   = 7'h20,
      S_WIN    = 7'h40
   } fcs_state_t;

   typedef struct packed {
      fcs_op_t     op;
      logic [18:0] addr;
      logic [7:0]  data;
   } fcs_req_t;

   typedef struct packed {
      logic [7:0] data;
      logic       fail;
   } fcs_resp_t;

   typedef struct packed {
      logic [18:0] addr;
      logic [7:0]  data;
   } fcs_bus_t;

endpackage
`default_nettype wire

// file: src/fcs_host.sv
// What this block does
// - byte program is four writes
// - bypass program is A0h then address/data
// - bypass exit is 90h then 00h
// - chip erase is six writes
// - sector erase sixth write carries sector, 30h
// - host spaces sector additions under 50 us
// - unlock is AA@555 then 55@2AA
`timescale 1ns/1ps
`default_nettype none
`include "fcs_defines.svh"
module fcs_host
   import fcs_pkg::*;
#(
   parameter int ADD_CYC = `FCS_ADD_CYC
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // user request
   input  wire logic        req_valid_i,
   input  wire fcs_req_t    req_i,
   output logic             req_ready_o,
   // user answer
   output logic             resp_valid_o,
   output fcs_resp_t        resp_o,
   // flash pins
   output logic [18:0]      fl_addr_o,
   input  wire logic [7:0]  fl_dq_i,
   output logic [7:0]       fl_dq_o,
   output logic             fl_dq_oe_n_o,
   output logic             fl_ce_n_o,
   output logic             fl_we_n_o,
   output logic             fl_oe_n_o
);

   // ---------------------------------------------------------
   // constants
   // ---------------------------------------------------------
   localparam logic [10:0] WP_CYC = 11'(`FCS_WP_CYC);
   localparam logic [10:0] RD_CYC = 11'(`FCS_RD_CYC);
   localparam logic [10:0] WN_CYC = 11'(ADD_CYC);

   // ---------------------------------------------------------
   // state
   // ---------------------------------------------------------
   fcs_state_t  state;        // sequencer state
   fcs_state_t  next_state;   // its next value
   fcs_op_t     op;           // operation in progress
   logic [18:0] addr;         // user address
   logic [7:0]  data;         // user data
   logic [2:0]  idx;          // write index within sequence
   logic [10:0] cnt;          // cycle counter
   logic        polling;      // reads are status polls
   logic        first;        // no earlier poll sample
   logic        prev6;        // toggle bit of last sample
   logic        fail;         // timing failure seen
   logic [7:0]  rd_data;      // last sampled byte
   logic [7:0]  dq_s1;        // synchroniser stage one
   logic [7:0]  dq_s2;        // synchroniser stage two
   logic        fire;         // request taken
   logic        fail_go;      // timing failure: reset next
   logic        toggled;      // toggle bit moved
   logic        last_w;       // last write of sequence
   fcs_op_t     s_op;         // operation for next write
   logic [2:0]  s_idx;        // index for next write
   fcs_bus_t    step;         // address/data for next write

   // ---------------------------------------------------------
   // functions
   // ---------------------------------------------------------
   // writes in each sequence
   function automatic logic [2:0] op_writes(input fcs_op_t o);
      case (o)
         OP_READ:                      op_writes = 3'h0;
         OP_IDENT, OP_BYP_ENTER:       op_writes = 3'h3;
         OP_PROG:                      op_writes = 3'h4;
         OP_BYP_PROG, OP_BYP_EXIT:     op_writes = 3'h2;
         OP_CHIP, OP_SECT:             op_writes = 3'h6;
         default:                      op_writes = 3'h1;
      endcase
   endfunction

   // address and data of one write; high bits stay zero except on writes that carry the user address
   function automatic fcs_bus_t cmd_step(input fcs_op_t o, input logic [2:0] i,
                                         input logic [18:0] a, input logic [7:0] d);
      logic       unl;
      logic [7:0] cmd;
      cmd_step = '0;
      unl = (o == OP_PROG) || (o == OP_IDENT) || (o == OP_BYP_ENTER)
            || (o == OP_CHIP) || (o == OP_SECT);
      case (o)
         OP_PROG:      cmd = `FCS_CMD_PROG;
         OP_IDENT:     cmd = `FCS_CMD_IDENT;
         OP_BYP_ENTER: cmd = `FCS_CMD_BYPASS;
         default:      cmd = `FCS_CMD_ERASE;
      endcase
      if (unl && (i == 3'h0 || i == 3'h3) && o != OP_PROG) begin
         cmd_step.addr = {8'h00, `FCS_ADDR_UNLOCK1};
         cmd_step.data = `FCS_DATA_UNLOCK1;
      end else if (unl && i == 3'h0) begin
         cmd_step.addr = {8'h00, `FCS_ADDR_UNLOCK1};
         cmd_step.data = `FCS_DATA_UNLOCK1;
      end else if (unl && (i == 3'h1 || i == 3'h4)) begin
         cmd_step.addr = {8'h00, `FCS_ADDR_UNLOCK2};
         cmd_step.data = `FCS_DATA_UNLOCK2;
      end else if (unl && i == 3'h2) begin
         cmd_step.addr = {8'h00, `FCS_ADDR_UNLOCK1};
         cmd_step.data = cmd;
      end else begin
         case (o)
            OP_PROG: begin
               cmd_step.addr = a;
               cmd_step.data = d;
            end
            OP_CHIP: begin
               cmd_step.addr = {8'h00, `FCS_ADDR_UNLOCK1};
               cmd_step.data = `FCS_CMD_CHIP;
            end
            OP_SECT, OP_SECT_ADD: begin
               cmd_step.addr = a;
               cmd_step.data = `FCS_CMD_SECT;
            end
            OP_BYP_PROG: begin
               cmd_step.addr = (i == 3'h0) ? 19'h00000 : a;
               cmd_step.data = (i == 3'h0) ? `FCS_CMD_PROG : d;
            end
            OP_BYP_EXIT: cmd_step.data = (i == 3'h0) ? `FCS_CMD_IDENT
                                                     : `FCS_CMD_BYP_EXIT2;
            OP_SUSPEND:  cmd_step.data = `FCS_CMD_SUSPEND;
            OP_RESUME:   cmd_step.data = `FCS_CMD_RESUME;
            default:     cmd_step.data = `FCS_CMD_RESET;
         endcase
      end
   endfunction

   // ---------------------------------------------------------
   // handshake and step selection
   // ---------------------------------------------------------
   // in the window only sector additions or suspend pass
   assign req_ready_o = (state == S_IDLE) ||
                        (state == S_WIN && (req_i.op == OP_SECT_ADD ||
                                            req_i.op == OP_SUSPEND));
   assign fire    = req_valid_i && req_ready_o;
   assign toggled = rd_data[`FCS_BIT_TOGGLE] != prev6;
   assign fail_go = (state == S_RGAP) && polling && !first && toggled
                    && rd_data[`FCS_BIT_TFAIL];
   assign last_w  = (idx + 3'h1) == op_writes(op);
   assign s_op    = fire ? req_i.op : (fail_go ? OP_RESET : op);
   assign s_idx   = (fire || fail_go) ? 3'h0 : ((state == S_WGAP) ? idx + 3'h1 : idx);
   assign step    = cmd_step(s_op, s_idx, fire ? req_i.addr : addr,
                             fire ? req_i.data : data);

   // ---------------------------------------------------------
   // next state
   // ---------------------------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         S_IDLE:   if (fire) begin
            next_state = (req_i.op == OP_READ) ? S_READ : S_WADDR;
         end
         S_WADDR:  next_state = S_WPULSE;
         S_WPULSE: if (cnt == WP_CYC - 11'h1) begin
            next_state = S_WGAP;
         end
         S_WGAP:   if (!last_w) begin
            next_state = S_WADDR;
         end else if (fail) begin
            next_state = S_IDLE;
         end else if (op == OP_PROG || op == OP_BYP_PROG || op == OP_CHIP) begin
            next_state = S_READ;
         end else if (op == OP_SECT || op == OP_SECT_ADD) begin
            next_state = S_WIN;
         end else begin
            next_state = S_IDLE;
         end
         S_READ:   if (cnt == RD_CYC - 11'h1) begin
            next_state = S_RGAP;
         end
         S_RGAP:   if (fail_go) begin
            next_state = S_WADDR;
         end else if (polling && (first || toggled)) begin
            next_state = S_READ;
         end else begin
            next_state = S_IDLE;
         end
         S_WIN:    if (fire) begin
            next_state = S_WADDR;
         end else if (cnt == WN_CYC - 11'h1) begin
            next_state = S_READ;
         end
         default:  next_state = S_IDLE;
      endcase
   end

   // ---------------------------------------------------------
   // state and counter
   // ---------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= S_IDLE;
         cnt   <= 11'h000;
      end else begin
         state <= next_state;
         cnt   <= (next_state != state || fire) ? 11'h000 : cnt + 11'h001;
      end
   end

   // ---------------------------------------------------------
   // operation registers
   // ---------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         op      <= OP_READ;
         addr    <= 19'h00000;
         data    <= 8'h00;
         idx     <= 3'h0;
         polling <= 1'b0;
         first   <= 1'b0;
         prev6   <= 1'b0;
         fail    <= 1'b0;
      end else begin
         if (fire) begin
            op    <= req_i.op;
            addr  <= req_i.addr;
            data  <= req_i.data;
            idx   <= 3'h0;
            fail  <= 1'b0;
         end else if (fail_go) begin
            op    <= OP_RESET;
            idx   <= 3'h0;
            fail  <= 1'b1;
         end else if (state == S_WGAP && !last_w) begin
            idx   <= idx + 3'h1;
         end
         if (state == S_IDLE) begin
            polling <= 1'b0;
         end else if (next_state == S_READ && state != S_RGAP && state != S_READ) begin
            polling <= (state != S_IDLE);
            first   <= 1'b1;
         end else if (state == S_RGAP) begin
            first   <= 1'b0;
            prev6   <= rd_data[`FCS_BIT_TOGGLE];
         end
      end
   end

   // ---------------------------------------------------------
   // pin input synchroniser and sample
   // ---------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dq_s1   <= 8'h00;
         dq_s2   <= 8'h00;
         rd_data <= 8'h00;
      end else begin
         dq_s1 <= fl_dq_i;
         dq_s2 <= dq_s1;
         if (state == S_READ && cnt == RD_CYC - 11'h1) begin
            rd_data <= dq_s2;
         end
      end
   end

   // ---------------------------------------------------------
   // flash pins, set from the next state
   // ---------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fl_addr_o    <= 19'h00000;
         fl_dq_o      <= 8'h00;
         fl_dq_oe_n_o <= 1'b1;
         fl_ce_n_o    <= 1'b1;
         fl_we_n_o    <= 1'b1;
         fl_oe_n_o    <= 1'b1;
      end else begin
         fl_we_n_o <= (next_state != S_WPULSE);
         fl_oe_n_o <= (next_state != S_READ);
         fl_ce_n_o <= !(next_state == S_WADDR || next_state == S_WPULSE ||
                        next_state == S_WGAP || next_state == S_READ);
         if (next_state == S_WADDR) begin
            fl_addr_o    <= step.addr;
            fl_dq_o      <= step.data;
            fl_dq_oe_n_o <= 1'b0;
         end else if (next_state == S_READ) begin
            fl_addr_o    <= fire ? req_i.addr : addr;
            fl_dq_oe_n_o <= 1'b1;
         end else if (next_state != S_WPULSE && next_state != S_WGAP) begin
            fl_dq_oe_n_o <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------
   // answer
   // ---------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         resp_valid_o <= 1'b0;
         resp_o       <= '0;
      end else begin
         resp_valid_o <= (next_state == S_IDLE) && (state != S_IDLE);
         if (next_state == S_IDLE && state != S_IDLE) begin
            resp_o.data <= rd_data;
            resp_o.fail <= fail;
         end
      end
   end

   // ---------------------------------------------------------
   // assertions
   // ---------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_unlock_first: assert property (
      state == S_WGAP && idx == 3'h0 && (op == OP_PROG || op == OP_CHIP || op == OP_SECT)
      |-> fl_addr_o[10:0] == `FCS_ADDR_UNLOCK1 && fl_dq_o == `FCS_DATA_UNLOCK1)
      else $error("first unlock write wrong");
   a_unlock_second: assert property (
      state == S_WGAP && idx == 3'h1 && (op == OP_PROG || op == OP_IDENT)
      |-> fl_addr_o[10:0] == `FCS_ADDR_UNLOCK2 && fl_dq_o == `FCS_DATA_UNLOCK2)
      else $error("second unlock write wrong");
   a_prog_four: assert property (
      state == S_WGAP && op == OP_PROG && idx == 3'h3 && !fail
      |=> state == S_READ ##1 polling)
      else $error("program not launched after fourth write");
   a_byp_prog: assert property (
      state == S_WGAP && op == OP_BYP_PROG && idx == 3'h0
      |-> fl_dq_o == `FCS_CMD_PROG ##[1:4] (state == S_WGAP && fl_dq_o == data))
      else $error("bypass program writes wrong");
   a_byp_exit: assert property (
      state == S_WGAP && op == OP_BYP_EXIT && idx == 3'h1 |-> fl_dq_o == `FCS_CMD_BYP_EXIT2
      ##1 state == S_IDLE)
      else $error("bypass exit second write wrong");
   a_chip_six: assert property (
      state == S_WGAP && op == OP_CHIP && idx == 3'h5
      |-> fl_dq_o == `FCS_CMD_CHIP && fl_addr_o[10:0] == `FCS_ADDR_UNLOCK1)
      else $error("chip erase command wrong");
   a_sect_cmd: assert property (
      state == S_WGAP && op == OP_SECT && idx == 3'h5
      |-> fl_dq_o == `FCS_CMD_SECT && fl_addr_o == addr ##1 state == S_WIN)
      else $error("sector erase command wrong");
   a_win_bound: assert property (
      state == S_WIN |-> cnt < WN_CYC)
      else $error("sector window overran");
   a_fail_reset: assert property (
      fail_go |-> ##[1:4] (state == S_WGAP && fl_dq_o == `FCS_CMD_RESET && fail))
      else $error("no reset after timing failure");
   a_strobe_excl: assert property (
      !fl_we_n_o |-> fl_oe_n_o && !fl_ce_n_o && !fl_dq_oe_n_o && $stable(fl_addr_o))
      else $error("write strobe overlaps read");

   c_prog_done: cover property (state == S_RGAP && op == OP_PROG ##1 state == S_IDLE);
   c_sect_add:  cover property (state == S_WIN && fire && req_i.op == OP_SECT_ADD);
   c_fail:      cover property (fail_go);
   c_ident:     cover property (state == S_WGAP && op == OP_IDENT && last_w);

endmodule
`default_nettype wire

// file: testbench/fcs_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module fcs_flash_model #(
   parameter logic [7:0] MAKER   = 8'h3c, // arbitrary value
   parameter logic [7:0] PART    = 8'hc5, // arbitrary value
   parameter int         PROG_T  = 400,   // program time, 10 ns ticks
   parameter int         ERASE_T = 1000,  // erase time, 10 ns ticks
   parameter int         WIN_T   = 200    // shortened sector add window
) (
   // flash pins
   input  wire logic [18:0] addr_i,
   input  wire logic [7:0]  dq_i,
   output logic [7:0]       dq_o,
   input  wire logic        ce_n_i,
   input  wire logic        we_n_i,
   input  wire logic        oe_n_i
);
   logic [7:0]  mem [0:4095]; // sparse image: sector plus low bits
   logic [18:0] la;           // address latched by the write
   logic [7:0]  pd, er, last; // program byte, erase set, last byte shown
   logic [11:0] pi;           // image index being programmed
   logic [1:0]  mode;         // 0 array, 1 ident, 2 bypass
   logic        susp, tfail, tog;
   int          seq, pl, wl, el; // command step, program/window/erase ticks
   wire logic       busy = pl > 0 || wl > 0 || el > 0 || tfail;
   wire logic [7:0] stat = {(wl > 0 || el > 0) ? 1'b0 : ~pd[7], tog, tfail, 5'h00};
   wire logic [7:0] idb  = addr_i[7:0] == 8'h00 ? MAKER : addr_i[7:0] == 8'h01 ? PART : 8'h00;
   wire logic [7:0] rd   = (busy && !(susp && !er[addr_i[18:16]])) ? stat
                         : mode == 2'd1 ? idb : mem[{addr_i[18:16], addr_i[8:0]}];
   // released bus shows the inverse of the last byte
   assign dq_o = (!ce_n_i && !oe_n_i) ? rd : ~last;
   // power-up state: array read
   initial begin
      for (int i = 0; i < 4096; i++)
         mem[i] = 8'hff;
      {mode, susp, tfail, tog, er, last, pd} = '0;
      {seq, pl, wl, el} = '0;
   end
   // chip select falls in the same step as output enable: settle first
   always @(negedge oe_n_i) begin
      #1;
      if (!ce_n_i && busy) tog = ~tog;
   end
   always @(posedge oe_n_i) last = rd;
   always @(negedge we_n_i) if (!ce_n_i) la = addr_i;
   // device timers
   always #10 begin
      if (pl > 0 && !tfail) begin
         pl--;
         if (pl == 0) mem[pi] = mem[pi] & pd;
      end
      if (!susp && wl > 0) begin
         wl--;
         if (wl == 0) el = ERASE_T;
      end else if (!susp && el > 0) begin
         el--;
         if (el == 0) begin
            for (int i = 0; i < 4096; i++)
               if (er[i[11:9]]) mem[i] = 8'hff;
            er = 8'h00;
         end
      end
   end
   // command decode, data taken at write strobe rise
   always @(posedge we_n_i) begin
      if (ce_n_i) begin
      end else if (pl > 0 && !tfail) begin
      end else if (tfail || (el > 0 && !susp)) begin
         if (tfail && dq_i == 8'hf0) {tfail, pl, mode, seq} = '0;
         else if (!tfail && dq_i == 8'hb0) susp = 1'b1;
      end else if (wl > 0 && !susp) begin
         if (dq_i == 8'h30) begin
            er[la[18:16]] = 1'b1;
            wl = WIN_T;
         end else if (dq_i == 8'hb0) susp = 1'b1;
         else {wl, er, seq} = '0;
      end else if (seq == 3) begin
         pd = dq_i;
         pi = {la[18:16], la[8:0]};
         pl = PROG_T;
         tfail = |(pd & ~mem[pi]);
         seq = 0;
      end else if (susp && dq_i == 8'h30) susp = 1'b0;
      else if (dq_i == 8'hf0) {mode, seq} = '0;
      else if (mode == 2'd2) begin
         if (seq == 7 && dq_i == 8'h00) {mode, seq} = '0;
         else seq = (seq == 0 && dq_i == 8'ha0) ? 3 : (seq == 0 && dq_i == 8'h90) ? 7 : 0;
      end else if (mode == 2'd0) begin
         if (seq == 0 || seq == 4) seq = (la[10:0] == 11'h555 && dq_i == 8'haa) ? seq + 1 : 0;
         else if (seq == 1 || seq == 5) seq = (la[10:0] == 11'h2aa && dq_i == 8'h55) ? seq + 1 : 0;
         else if (seq == 2 && la[10:0] == 11'h555) begin
            if (dq_i == 8'h90) mode = 2'd1;
            if (dq_i == 8'h20) mode = 2'd2;
            seq = dq_i == 8'ha0 ? 3 : dq_i == 8'h80 ? 4 : 0;
         end else if (seq == 6 && dq_i == 8'h10 && la[10:0] == 11'h555) begin
            er = 8'hff;
            el = ERASE_T;
            seq = 0;
         end else if (seq == 6 && dq_i == 8'h30) begin
            er[la[18:16]] = 1'b1;
            wl = WIN_T;
            seq = 0;
         end else seq = 0;
      end
   end
endmodule
`default_nettype wire

// file: testbench/fcs_host_bench.sv
`timescale 1ns/1ps
`default_nettype none
module fcs_host_bench;
   import fcs_pkg::*;
   localparam int ADD_CYC = 20; // shortened sector add window
   typedef struct packed { logic chk; logic [7:0] data; logic fail; } fcs_note_t;
   logic       clk_i, rst_i, req_valid_i;
   fcs_req_t   req_i;
   logic       req_ready_o, resp_valid_o;
   fcs_resp_t  resp_o;
   logic [18:0] fl_addr_o;
   logic [7:0] fl_dq_o, mdl_dq;
   logic       fl_dq_oe_n_o, fl_ce_n_o, fl_we_n_o, fl_oe_n_o;
   wire logic [7:0] fl_dq_i = !fl_dq_oe_n_o ? fl_dq_o : mdl_dq; // wire level
   fcs_note_t  notes[$];     // expected answers, oldest first
   int         mismatches, comparisons;
   fcs_host #(.ADD_CYC(ADD_CYC)) dut (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
      .req_i(req_i), .req_ready_o(req_ready_o), .resp_valid_o(resp_valid_o), .resp_o(resp_o),
      .fl_addr_o(fl_addr_o), .fl_dq_i(fl_dq_i), .fl_dq_o(fl_dq_o), .fl_dq_oe_n_o(fl_dq_oe_n_o),
      .fl_ce_n_o(fl_ce_n_o), .fl_we_n_o(fl_we_n_o), .fl_oe_n_o(fl_oe_n_o));
   fcs_flash_model mdl (.addr_i(fl_addr_o), .dq_i(fl_dq_i), .dq_o(mdl_dq), .ce_n_i(fl_ce_n_o),
      .we_n_i(fl_we_n_o), .oe_n_i(fl_oe_n_o));
   initial clk_i = 1'b0;
   always #20 clk_i = ~clk_i;
   // -----------------------------------------------------------
   // checking and closing
   // -----------------------------------------------------------
   task automatic cmp_data(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp_fail(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t fail got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      if (mismatches == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // answers are matched against the oldest note
   always @(negedge clk_i) begin
      fcs_note_t n;
      if (resp_valid_o === 1'b1) begin
         if (notes.size() > 0) n = notes.pop_front();
         else n = fcs_note_t'{1'b0, 8'h00, 1'bx};
         if (n.chk) cmp_data(resp_o.data, n.data);
         cmp_fail(resp_o.fail, n.fail);
      end
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      mismatches++;
      summarize();
   end
   // -----------------------------------------------------------
   // request driver
   // -----------------------------------------------------------
   task automatic send(input fcs_op_t op, input logic [18:0] a, input logic [7:0] d,
                       input logic ans, input logic chk, input logic [7:0] ed, input logic ef);
      int n;
      @(negedge clk_i);
      req_valid_i = 1'b1;
      req_i = '{op, a, d};
      if (ans) notes.push_back(fcs_note_t'{chk, ed, ef});
      n = 0;
      while (req_ready_o !== 1'b1 && n < 5000) begin
         @(negedge clk_i);
         n++;
      end
      if (n >= 5000) mismatches++;
      @(posedge clk_i);
      @(negedge clk_i);
      req_valid_i = 1'b0;
   endtask
   task automatic rd(input logic [18:0] a, input logic [7:0] e);
      send(OP_READ, a, 8'h00, 1'b1, 1'b1, e, 1'b0);
   endtask
   task automatic op(input fcs_op_t o, input logic [18:0] a, input logic [7:0] d);
      send(o, a, d, 1'b1, 1'b0, 8'h00, 1'b0);
   endtask
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // -----------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------
   initial begin
      logic [31:0] seed;
      logic [7:0]  b1, b2, b3;
      seed = 32'h098bb6f0;
      req_valid_i = 1'b0;
      req_i = '0;
      rst_i = 1'b1;
      repeat (6) @(posedge clk_i);
      @(negedge clk_i);
      rst_i = 1'b0;
      seed = lfsr(seed);
      b1 = seed[7:0];
      seed = lfsr(seed);
      b2 = seed[15:8];
      seed = lfsr(seed);
      b3 = seed[23:16];
      rd(19'h00100, 8'hff);
      op(OP_PROG, 19'h00100, 8'h5a);
      rd(19'h00100, 8'h5a);
      send(OP_PROG, 19'h00100, 8'hff, 1'b1, 1'b0, 8'h00, 1'b1);
      rd(19'h00100, 8'h5a);
      op(OP_IDENT, 19'h00000, 8'h00);
      rd(19'h70000, mdl.MAKER);
      rd(19'h70001, mdl.PART);
      rd(19'h30002, 8'h00);
      op(OP_RESET, 19'h12345, 8'h00);
      rd(19'h00100, 8'h5a);
      op(OP_BYP_ENTER, 19'h00000, 8'h00);
      op(OP_BYP_PROG, 19'h50010, b1);
      op(OP_BYP_PROG, 19'h60020, b2);
      op(OP_BYP_EXIT, 19'h00000, 8'h00);
      rd(19'h50010, b1);
      rd(19'h60020, b2);
      send(OP_SECT, 19'h50010, 8'h00, 1'b0, 1'b0, 8'h00, 1'b0);
      op(OP_SECT_ADD, 19'h60020, 8'h00);
      rd(19'h50010, 8'hff);
      rd(19'h60020, 8'hff);
      op(OP_PROG, 19'h30040, b3);
      send(OP_SECT, 19'h30040, 8'h00, 1'b0, 1'b0, 8'h00, 1'b0);
      op(OP_SUSPEND, 19'h00000, 8'h00);
      rd(19'h00100, 8'h5a);
      op(OP_RESUME, 19'h00000, 8'h00);
      repeat (400) @(negedge clk_i);
      rd(19'h30040, 8'hff);
      op(OP_CHIP, 19'h00000, 8'h00);
      rd(19'h00100, 8'hff);
      for (int i = 0; i < 2000 && notes.size() > 0; i++)
         @(negedge clk_i);
      if (notes.size() != 0) mismatches++;
      summarize();
   end
endmodule
`default_nettype wire
